/* File: hw/rtcie_pkg.sv */
// Package of register map, field positions and timing counts for the interrupt enable block
package rtcie_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] RTCIE_OFS_CTRL   = 8'h00;
  localparam logic [7:0] RTCIE_OFS_STATUS = 8'h04;
  localparam logic [7:0] RTCIE_OFS_CLEAR  = 8'h08;
  localparam logic [7:0] RTCIE_OFS_IEN    = 8'h0C;
  localparam logic [7:0] RTCIE_OFS_PINST  = 8'h10;

  // ==========================================================
  // Control fields
  localparam int RTCIE_CTRL_UIE  = 0;
  localparam int RTCIE_CTRL_TIE  = 1;
  localparam int RTCIE_CTRL_AIE  = 2;
  localparam int RTCIE_CTRL_MIN  = 3;
  localparam logic [3:0] RTCIE_CTRL_RST = 4'h0;

  // Status fields (sticky events, same layout for clear and enable)
  localparam int RTCIE_ST_UPD   = 0;
  localparam int RTCIE_ST_CNT   = 1;
  localparam int RTCIE_ST_ALM   = 2;
  localparam int RTCIE_ST_W     = 3;

  // ==========================================================
  // Timing
  localparam int  RTCIE_CLK_HZ       = 50_000_000;
  localparam int  RTCIE_UPW_SEC_US   = 500_000;   // 500 ms
  localparam int  RTCIE_UPW_MIN_US   = 15_600;    // 15.6 ms
  localparam int  RTCIE_CPW_US       = 7_813;     // countdown width, 7.813 ms
  localparam longint RTCIE_UPW_SEC_CYC = (longint'(RTCIE_UPW_SEC_US) * RTCIE_CLK_HZ) / 1_000_000;
  localparam longint RTCIE_UPW_MIN_CYC = (longint'(RTCIE_UPW_MIN_US) * RTCIE_CLK_HZ) / 1_000_000;
  localparam longint RTCIE_CPW_CYC     = (longint'(RTCIE_CPW_US) * RTCIE_CLK_HZ) / 1_000_000;

  // Pulse timer state
  typedef enum logic [1:0] {RTCIE_IDLE = 2'b00, RTCIE_LOW = 2'b01} rtcie_pulse_e;

  // Event bundle
  typedef struct packed {
    logic alarm;
    logic countdown;
    logic update;
  } rtcie_evt_s;

endpackage

/* File: hw/rtcie_pulse.sv */
// Self-releasing low pulse timer for one interrupt source
`timescale 1ns/1ps
`default_nettype none
module rtcie_pulse
  import rtcie_pkg::*;
#(
  parameter int CW = 25
)(
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control
  input  wire logic          enable,
  input  wire logic          trigger,
  input  wire logic [CW-1:0] width,
  // Result
  output logic               active
);

  rtcie_pulse_e st_q;
  rtcie_pulse_e st_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // A one-bit counter cannot hold a width and its expiry apart
  if (CW < 2)
  begin : g_bad_cw
    $error("rtcie_pulse: counter width too small");
  end

  // Next state: retrigger restarts, disable cancels, count expiry releases
  always_comb
  begin
    st_d  = st_q;
    cnt_d = cnt_q;
    if (!enable)
    begin
      st_d  = RTCIE_IDLE;
      cnt_d = '0;
    end
    else if (trigger)
    begin
      st_d  = RTCIE_LOW;
      cnt_d = width;
    end
    else if (st_q == RTCIE_LOW)
    begin
      if (cnt_q <= CW'(1))
        st_d = RTCIE_IDLE;
      cnt_d = cnt_q - CW'(1);
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q  <= RTCIE_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign active = (st_q == RTCIE_LOW);

endmodule
`default_nettype wire

/* File: hw/rtcie_top.sv */
// Interrupt enable gating for update, countdown and alarm events with APB registers
// Behaviour
// - Update disabled: no output, no flag, cancel
// - Update enabled: drive low, set flag
// - Update pulse self-releases after its width
// - Countdown disabled: no output, cancel pulse
// - Countdown enabled: low pulse, self-releases
`timescale 1ns/1ps
`default_nettype none
module rtcie_top
  import rtcie_pkg::*;
#(
  parameter longint UPD_SEC_CYC = RTCIE_UPW_SEC_CYC,
  parameter longint UPD_MIN_CYC = RTCIE_UPW_MIN_CYC,
  parameter longint CNT_CYC     = RTCIE_CPW_CYC
)(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Event pulses from the timebase, same clock
  input  wire logic        update_evt,
  input  wire logic        countdown_evt,
  input  wire logic        alarm_evt,
  // Alarm flag cleared by host
  input  wire logic        alarm_flag_clear,
  // Device pin and flags
  output logic             int_n,
  output logic             update_event_flag,
  output logic             irq
);

  localparam int CW = 25;

  // Widths must fit the pulse counters; refused at elaboration, not at run time
  if (UPD_SEC_CYC < 1 || UPD_MIN_CYC < 1 || CNT_CYC < 1 ||
      UPD_SEC_CYC >= (longint'(1) << CW) || CNT_CYC >= (longint'(1) << CW) ||
      UPD_MIN_CYC >= (longint'(1) << CW))
  begin : g_bad_width
    $error("rtcie_top: pulse width parameter out of range");
  end

  // ==========================================================
  // Registers
  logic [3:0]          ctrl_q, ctrl_d;
  logic [RTCIE_ST_W-1:0] stat_q, stat_d;
  logic [RTCIE_ST_W-1:0] ien_q, ien_d;
  logic                uf_q, uf_d;
  logic                alm_q, alm_d;
  logic [31:0]         rd_q, rd_d;
  logic                wr, rd, wr_clr;
  logic                update_irq_enable, countdown_irq_enable, alarm_irq_enable;
  logic                upd_act, cnt_act;
  logic [CW-1:0]       upd_width;
  rtcie_evt_s          evt;

  assign update_irq_enable    = ctrl_q[RTCIE_CTRL_UIE];
  assign countdown_irq_enable = ctrl_q[RTCIE_CTRL_TIE];
  assign alarm_irq_enable     = ctrl_q[RTCIE_CTRL_AIE];
  assign evt     = '{alarm: alarm_evt, countdown: countdown_evt, update: update_evt};
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign wr_clr  = wr && (paddr == RTCIE_OFS_CLEAR);
  // Minute mode selects the short update pulse
  assign upd_width = ctrl_q[RTCIE_CTRL_MIN] ? CW'(UPD_MIN_CYC) : CW'(UPD_SEC_CYC);

  // ==========================================================
  // Pulse timers
  rtcie_pulse #(.CW(CW)) u_upd (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (update_irq_enable),
    .trigger (evt.update),
    .width   (upd_width),
    .active  (upd_act)
  );

  rtcie_pulse #(.CW(CW)) u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (countdown_irq_enable),
    .trigger (evt.countdown),
    .width   (CW'(CNT_CYC)),
    .active  (cnt_act)
  );

  // ==========================================================
  // Next values: flags, alarm hold, register writes, read data
  always_comb
  begin
    ctrl_d = ctrl_q;
    ien_d  = ien_q;
    uf_d   = uf_q;
    alm_d  = alm_q;
    stat_d = stat_q;
    rd_d   = rd_q;
    // Flag set only while enabled; set wins over host clear
    if (evt.update && update_irq_enable)
      uf_d = 1'b1;
    else if (wr_clr && pwdata[RTCIE_ST_UPD])
      uf_d = 1'b0;
    // Alarm held until its flag is cleared; disable cancels
    if (!alarm_irq_enable)
      alm_d = 1'b0;
    else if (evt.alarm)
      alm_d = 1'b1;
    else if (alarm_flag_clear)
      alm_d = 1'b0;
    // Sticky status, set wins over clear
    if (wr_clr)
      stat_d = stat_q & ~pwdata[RTCIE_ST_W-1:0];
    if (evt.update && update_irq_enable)
      stat_d[RTCIE_ST_UPD] = 1'b1;
    if (evt.countdown && countdown_irq_enable)
      stat_d[RTCIE_ST_CNT] = 1'b1;
    if (evt.alarm && alarm_irq_enable)
      stat_d[RTCIE_ST_ALM] = 1'b1;
    // Writes in access phase
    if (wr)
    begin
      if (paddr == RTCIE_OFS_CTRL)
        ctrl_d = pwdata[3:0];
      else if (paddr == RTCIE_OFS_IEN)
        ien_d = pwdata[RTCIE_ST_W-1:0];
    end
    // Read data captured in setup, so it is stable in access
    if (rd)
    begin
      rd_d = 32'h0000_0000;
      if (paddr == RTCIE_OFS_CTRL)
        rd_d[3:0] = ctrl_q;
      else if (paddr == RTCIE_OFS_STATUS)
        rd_d[RTCIE_ST_W-1:0] = stat_q;
      else if (paddr == RTCIE_OFS_IEN)
        rd_d[RTCIE_ST_W-1:0] = ien_q;
      else if (paddr == RTCIE_OFS_PINST)
        rd_d[3:0] = {alm_q, cnt_act, upd_act, uf_q};
      else if (paddr == RTCIE_OFS_CLEAR)
        rd_d = 32'h0000_0000;
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= RTCIE_CTRL_RST;
      ien_q  <= '0;
      stat_q <= '0;
      uf_q   <= 1'b0;
      alm_q  <= 1'b0;
      rd_q   <= 32'h0000_0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ien_q  <= ien_d;
      stat_q <= stat_d;
      uf_q   <= uf_d;
      alm_q  <= alm_d;
      rd_q   <= rd_d;
    end
  end

  // ==========================================================
  // Outputs; pin is low while any source is active
  assign int_n             = !(upd_act || cnt_act || alm_q);
  assign update_event_flag = uf_q;
  assign irq               = |(stat_q & ien_q);
  assign prdata            = rd_q;
  assign pready            = 1'b1;
  // Address decode of the five mapped words
  function automatic logic rtcie_mapped(input logic [7:0] a);
    return (a == RTCIE_OFS_CTRL) || (a == RTCIE_OFS_STATUS) || (a == RTCIE_OFS_IEN) ||
           (a == RTCIE_OFS_PINST) || (a == RTCIE_OFS_CLEAR);
  endfunction

  // Unmapped address: error flagged in the access phase itself, no wait state
  assign pslverr = psel && penable && !rtcie_mapped(paddr);

  // ==========================================================
  // Checks
  a_upd_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !update_irq_enable |=> !upd_act)
    else $error("update pulse active while disabled");
  a_upd_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (!update_irq_enable && !uf_q) |=> !uf_q)
    else $error("update flag set while disabled");
  a_upd_fires: assert property (@(posedge pclk) disable iff (!presetn)
    (update_evt && update_irq_enable) |=> (!int_n && uf_q))
    else $error("update event did not drive pin and flag");
  a_upd_release: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(upd_act) |-> ($past(u_upd.cnt_q) <= CW'(1) || !$past(update_irq_enable)))
    else $error("update pulse released early");
  a_cnt_off_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !countdown_irq_enable |=> !cnt_act)
    else $error("countdown pulse active while disabled");
  a_cnt_fires: assert property (@(posedge pclk) disable iff (!presetn)
    (countdown_evt && countdown_irq_enable) |=> (cnt_act && !int_n))
    else $error("countdown event did not drive pin");
  a_cnt_release: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cnt_act) |-> cnt_act until_with (u_cnt.cnt_q <= CW'(1) || !countdown_irq_enable
    || countdown_evt))
    else $error("countdown pulse ended without expiry");
  a_alm_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (alm_q && alarm_irq_enable && !alarm_flag_clear) |=> alm_q)
    else $error("alarm level dropped before flag clear");
  a_alm_cancel: assert property (@(posedge pclk) disable iff (!presetn)
    !alarm_irq_enable |=> !alm_q)
    else $error("alarm level held while disabled");

endmodule
`default_nettype wire

/* File: tb/rtcie_host.sv */
// Host model that times each low pulse on the interrupt pin
`timescale 1ns/1ps
`default_nettype none
module rtcie_host
(
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Interrupt pin
  input  wire logic   int_n,
  // Measured pulse
  output logic        done,
  output logic [31:0] width
);
  logic [31:0] cnt_q;

  // Count low cycles, report once on release
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_q <= '0;
      done  <= 1'b0;
      width <= '0;
    end
    else
    begin
      done  <= int_n && (cnt_q != 0);
      width <= cnt_q;
      cnt_q <= int_n ? '0 : cnt_q + 1;
    end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtcie_pkg::*;
  localparam int US = 20, UM = 10, UC = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, width;
  logic [3:0]  ev;
  logic        int_n, update_event_flag, irq, done;
  int          n_fail = 0, n_tests = 0, q[$], e, m;

  // ==========================================================
  // Design and host
  rtcie_top #(.UPD_SEC_CYC(US), .UPD_MIN_CYC(UM), .CNT_CYC(UC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .update_evt(ev[0]),
    .countdown_evt(ev[1]), .alarm_evt(ev[2]), .alarm_flag_clear(ev[3]),
    .int_n(int_n), .update_event_flag(update_event_flag), .irq(irq));
  rtcie_host i_host (.pclk(pclk), .presetn(presetn), .int_n(int_n),
    .done(done), .width(width));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // ==========================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // One-cycle pulse on event line k
  task automatic pulse(input int k);
    @(posedge pclk);
    ev <= 4'h1 << k;
    @(posedge pclk);
    ev <= 4'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Each pulse on the pin is judged against the oldest note; zero means cut short
  // Sampled mid-cycle, away from the edge that launches the host's report
  always @(negedge pclk)
    if (done)
    begin
      e = (q.size() > 0) ? q.pop_front() : -1;
      if (e < 0)
        chk("unexpected pulse", 32'h1, 32'h0);
      else
        chk("pulse width", e ? width : 32'(width < UC), e ? e : 1);
    end

  initial
  begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    close_out();
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    void'($urandom(32230));
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, RTCIE_OFS_CTRL, 0);
    chk("ctrl reset", rd, 32'h0);
    chk("pin idle", int_n, 1'b1);
    apb(0, 8'h40, 0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1, RTCIE_OFS_IEN, 32'h7);
    // Second then minute update pulses
    apb(1, RTCIE_OFS_CTRL, 32'h1);
    q.push_back(US);
    pulse(0);
    idle(1);
    chk("flag", update_event_flag, 1'b1);
    chk("pin low", int_n, 1'b0);
    chk("irq", irq, 1'b1);
    apb(0, RTCIE_OFS_STATUS, 0);
    chk("status", rd, 32'h1);
    apb(1, RTCIE_OFS_CLEAR, 32'h7);
    chk("irq clr", irq, 1'b0);
    chk("flag clr", update_event_flag, 1'b0);
    idle(25);
    apb(1, RTCIE_OFS_CTRL, 32'h9);
    q.push_back(UM);
    pulse(0);
    idle(25);
    chk("flag min", update_event_flag, 1'b1);
    // Flag and status start clean, so the disabled case below is telling
    apb(1, RTCIE_OFS_CLEAR, 32'h7);
    // Countdown with update disabled; mask keeps irq low
    apb(1, RTCIE_OFS_IEN, 32'h0);
    apb(1, RTCIE_OFS_CTRL, 32'h2);
    q.push_back(UC);
    pulse(1);
    pulse(0);
    idle(1);
    chk("irq masked", irq, 1'b0);
    idle(25);
    chk("flag off", update_event_flag, 1'b0);
    apb(0, RTCIE_OFS_STATUS, 0);
    chk("status cnt", rd, 32'h2);
    apb(1, RTCIE_OFS_CLEAR, 32'h7);
    // Clearing an enable cancels its pulse, for every source
    for (int k = 0; k < 3; k++)
    begin
      apb(1, RTCIE_OFS_CTRL, 32'h1 << k);
      q.push_back(0);
      pulse(k);
      apb(1, RTCIE_OFS_CTRL, 32'h0);
      idle(1);
      chk("cancel", int_n, 1'b1);
      idle(25);
    end
    // Alarm held for a random span, then a disabled alarm
    apb(1, RTCIE_OFS_CTRL, 32'h4);
    m = $urandom % 20;
    q.push_back(m + 2);
    pulse(2);
    repeat (m) @(posedge pclk);
    pulse(3);
    idle(5);
    chk("alarm released", int_n, 1'b1);
    apb(1, RTCIE_OFS_CTRL, 32'h0);
    pulse(2);
    idle(5);
    chk("alarm off", int_n, 1'b1);
    chk("notes left", q.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire
